// ==== dv/lpt_panel_model.sv ====
// panel model: counts the pixels shifted in on each line
`default_nettype none
module lpt_panel_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  pol,
  input  wire logic        shift_clock,
  input  wire logic        line_sync,
  input  wire logic        output_enable,
  output logic      [15:0] line_pixels
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_q;
  logic        ls_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0;
      ls_q <= 1'b0;
      line_pixels <= 16'h0;
    end else begin
      ls_q <= line_sync ^ pol[2];
      if ((line_sync ^ pol[2]) && !ls_q) begin
        cnt_q <= 16'h0;
        if (cnt_q != 16'h0) line_pixels <= cnt_q;
      end else if ((shift_clock ^ pol[0]) && (output_enable ^ pol[3])) begin
        cnt_q <= cnt_q + 16'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/lpt_timing_props.sv ====
// assertion checker for the panel timing generator
`default_nettype none
module lpt_timing_props #(
  parameter int DW = 8
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [DW-1:0] pixel_in,
  input wire logic          pixel_req,
  input wire logic [DW-1:0] pixel_data_out,
  input wire logic          shift_clock,
  input wire logic          line_sync,
  input wire logic          frame_sync,
  input wire logic          output_enable,
  input wire logic          line_start_pulse
);
  logic [31:0] ctl_q, htim_q, size_q, div_q;
  logic        ls_q, oe_q, sk_q, oev_q, lsv_q;
  logic [1:0]  skv_q;
  logic [15:0] lsr_q, lsf_q, oef_q, skr_q, u, hw, hf, hb, xm, lsp_q;
  logic        ls, oe, sk, en, am;
  // shadows, active levels
  assign ls = line_sync ^ ctl_q[lpt_pkg::CTRL_LSPOL];
  assign oe = output_enable ^ ctl_q[lpt_pkg::CTRL_OEPOL];
  assign sk = shift_clock ^ ctl_q[lpt_pkg::CTRL_SCKPOL];
  assign en = ctl_q[lpt_pkg::CTRL_EN];
  assign am = ctl_q[2:1] == lpt_pkg::MODE_ACTIVE;
  assign u  = {10'h0, div_q[5:0]} + 16'h1;
  assign hw = {8'h0, htim_q[7:0]} + 16'h1;
  assign hf = {8'h0, htim_q[15:8]} + 16'h1;
  assign hb = {8'h0, htim_q[23:16]} + 16'h3;
  assign xm = {4'h0, size_q[11:0]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q  <= lpt_pkg::CTRL_RST;
      htim_q <= lpt_pkg::HTIM_RST;
      size_q <= lpt_pkg::SIZE_RST;
      div_q  <= lpt_pkg::CLKDIV_RST;
    end else if (psel && penable && pwrite) begin
      if (paddr == lpt_pkg::CTRL_OFF) ctl_q <= pwdata;
      if (paddr == lpt_pkg::HTIM_OFF) htim_q <= pwdata;
      if (paddr == lpt_pkg::SIZE_OFF) size_q <= pwdata;
      if (paddr == lpt_pkg::CLKDIV_OFF) div_q <= pwdata;
    end
  end
  // edge ages, valid flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ls_q, oe_q, sk_q, oev_q, lsv_q} <= 5'h00;
      skv_q <= 2'h0;
      {lsr_q, lsf_q, oef_q, skr_q, lsp_q} <= 80'h0;
    end else begin
      ls_q  <= ls;
      oe_q  <= oe;
      sk_q  <= sk;
      lsr_q <= (ls && !ls_q) ? 16'h1 : lsr_q + 16'h1;
      lsf_q <= (!ls && ls_q) ? 16'h1 : lsf_q + 16'h1;
      oef_q <= (!oe && oe_q) ? 16'h1 : oef_q + 16'h1;
      skr_q <= (sk && !sk_q) ? 16'h1 : skr_q + 16'h1;
      lsp_q <= line_start_pulse ? lsp_q + 16'h1 : '0;
      lsv_q <= en && (lsv_q || (ls && !ls_q));
      oev_q <= en && ((oev_q && !(ls && !ls_q)) || (!oe && oe_q));
      if (!en) skv_q <= 2'h0;
      else if (sk && !sk_q && skv_q != 2'h3) skv_q <= skv_q + 2'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_reset_quiet;
    $rose(presetn) |-> !(line_sync || frame_sync || output_enable || shift_clock);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("busy after reset");
  property p_data_pol;
    pixel_req |=> pixel_data_out == ($past(pixel_in) ^ {DW{ctl_q[6]}});
  endproperty
  a_data_pol: assert property (p_data_pol) else $error("pixel data wrong");
  property p_sck_follow;
    pixel_req |=> sk;
  endproperty
  a_sck_follow: assert property (p_sck_follow) else $error("no shift pulse");
  property p_sck_gap;
    sk && !sk_q && skv_q >= 2'h2 && ctl_q[2:1] != lpt_pkg::MODE_MONO
      && ctl_q[11:10] == 2'h0 |-> skr_q == u;
  endproperty
  a_sck_gap: assert property (p_sck_gap) else $error("shift gap wrong");
  property p_ls_width;
    en && !ls && ls_q |-> lsr_q == hw * u;
  endproperty
  a_ls_width: assert property (p_ls_width) else $error("sync width wrong");
  property p_period;
    en && am && ls && !ls_q && lsv_q |-> lsr_q == (xm + hw + hf + hb) * u;
  endproperty
  a_period: assert property (p_period) else $error("line period wrong");
  property p_front;
    en && am && ls && !ls_q && oev_q |-> oef_q == hf * u;
  endproperty
  a_front: assert property (p_front) else $error("front wait wrong");
  property p_back;
    en && am && oe && !oe_q |-> lsf_q == hb * u;
  endproperty
  a_back: assert property (p_back) else $error("back wait wrong");
  property p_start_pulse;
    en && $fell(line_start_pulse) |-> lsp_q == u;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse wide");
endmodule
bind lpt_timing lpt_timing_props #(.DW(DW)) i_lpt_timing_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pixel_in(pixel_in),
  .pixel_req(pixel_req), .pixel_data_out(pixel_data_out),
  .shift_clock(shift_clock), .line_sync(line_sync),
  .frame_sync(frame_sync), .output_enable(output_enable),
  .line_start_pulse(line_start_pulse));
`default_nettype wire

// ==== dv/lpt_timing_tb_top.sv ====
// testbench for the panel timing generator
`default_nettype none
module lpt_timing_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, pixel_in = 8'h00, pixel_data_out;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, pixel_req, shift_clock, line_sync;
  logic        frame_sync, output_enable, line_start_pulse, gate_clock;
  logic        power_save_out, polarity_reverse;
  logic [3:0]  pol = 4'h0;
  logic [15:0] line_pixels;
  int          fails = 0, n_tests = 0;
  always #10 pclk = ~pclk;
  always @(posedge pclk) if (pixel_req) pixel_in <= pixel_in + 8'h01;
  lpt_timing #(.DW(8)) i_lpt_timing (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pixel_in(pixel_in), .pixel_req(pixel_req),
    .pixel_data_out(pixel_data_out), .shift_clock(shift_clock),
    .line_sync(line_sync), .frame_sync(frame_sync),
    .output_enable(output_enable), .line_start_pulse(line_start_pulse),
    .gate_clock(gate_clock), .power_save_out(power_save_out),
    .polarity_reverse(polarity_reverse));
  lpt_panel_model i_lpt_panel_model (.pclk(pclk), .presetn(presetn),
    .pol(pol), .shift_clock(shift_clock), .line_sync(line_sync),
    .output_enable(output_enable), .line_pixels(line_pixels));
  task automatic tally_and_finish;
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [32:0] r);
    int k;
    k = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = {pslverr, prdata};
    {psel, penable} <= 2'b00;
    @(posedge pclk);
    fails += int'(k >= 50);
    if (k >= 50) tally_and_finish();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  function automatic logic pick(input int s);
    return s == 0 ? line_sync : s == 1 ? gate_clock :
           s == 2 ? shift_clock : output_enable;
  endfunction
  task automatic wrise(input int s, input logic a);
    int k;
    k = 0;
    while (pick(s) !== !a && k < 5000) begin
      @(posedge pclk);
      k++;
    end
    while (pick(s) !== a && k < 5000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 5000) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic meas(input int s, input logic a, input bit per,
                      output int n);
    wrise(s, a);
    n = 0;
    while (pick(s) === a && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    while (per && pick(s) !== a && n < 5000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic wpix(input logic [15:0] v);
    int k;
    k = 0;
    while (line_pixels !== v && k < 5000) begin
      @(posedge pclk);
      k++;
    end
    chk({17'h0, line_pixels}, {17'h0, v});
  endtask
  task automatic t_reset;
    chk({29'h0, line_sync, frame_sync, output_enable, shift_clock}, 33'h0);
    rd(lpt_pkg::CTRL_OFF, {1'b0, lpt_pkg::CTRL_RST});
    rd(lpt_pkg::HTIM_OFF, {1'b0, lpt_pkg::HTIM_RST});
    rd(lpt_pkg::VTIM_OFF, {1'b0, lpt_pkg::VTIM_RST});
    rd(lpt_pkg::SIZE_OFF, {1'b0, lpt_pkg::SIZE_RST});
    rd(lpt_pkg::CLKDIV_OFF, {1'b0, lpt_pkg::CLKDIV_RST});
    rd(lpt_pkg::SEG_OFF, {1'b0, lpt_pkg::SEG_RST});
    rd(8'h1C, {1'b1, 32'h0});
  endtask
  task automatic t_active;
    int n;
    wr(lpt_pkg::HTIM_OFF, 32'h0001_0201);
    wr(lpt_pkg::SIZE_OFF, 32'h0002_0008);
    wr(lpt_pkg::VTIM_OFF, 32'h0001_0001);
    wr(lpt_pkg::CLKDIV_OFF, 32'h0000_0002);
    wr(lpt_pkg::CTRL_OFF, 32'h0000_0001);
    meas(0, 1'b1, 1'b1, n);
    chk(33'(n), 33'h33);
    meas(0, 1'b1, 1'b0, n);
    chk(33'(n), 33'h6);
    wpix(16'h8);
  endtask
  task automatic t_pol;
    int n;
    wr(lpt_pkg::CTRL_OFF, 32'h0);
    wr(lpt_pkg::SIZE_OFF, 32'h0002_0005);
    wr(lpt_pkg::CTRL_OFF, 32'h0000_03E0);
    pol <= 4'hF;
    wr(lpt_pkg::CTRL_OFF, 32'h0000_03E1);
    meas(0, 1'b0, 1'b0, n);
    chk(33'(n), 33'h6);
    meas(2, 1'b0, 1'b0, n);
    chk(33'(n), 33'h1);
    wpix(16'h5);
  endtask
  task automatic t_mono;
    int n;
    wr(lpt_pkg::CTRL_OFF, 32'h0000_0016);
    pol <= 4'h0;
    wr(lpt_pkg::SIZE_OFF, 32'h0002_0010);
    wr(lpt_pkg::CLKDIV_OFF, 32'h0);
    wr(lpt_pkg::CTRL_OFF, 32'h0000_0017);
    wrise(3, 1'b1);
    meas(2, 1'b1, 1'b1, n);
    chk(33'(n), 33'h4);
  endtask
  task automatic t_seg;
    int n;
    logic r;
    wr(lpt_pkg::CTRL_OFF, 32'h0000_0002);
    wr(lpt_pkg::CLKDIV_OFF, 32'h0000_0002);
    wr(lpt_pkg::SEG_OFF, 32'h0001_0201);
    wr(lpt_pkg::CTRL_OFF, 32'h0000_0003);
    meas(1, 1'b1, 1'b0, n);
    chk(33'(n), 33'h9);
    wrise(0, 1'b1);
    r = polarity_reverse;
    wrise(0, 1'b1);
    chk({32'h0, polarity_reverse ^ r}, 33'h1);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_active();
    t_pol();
    t_mono();
    t_seg();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== hdl/lpt_pkg.sv ====
// constants, register map and state types of the panel timing generator
`default_nettype none
package lpt_pkg;
  localparam logic [7:0]  CTRL_OFF   = 8'h00;
  localparam logic [7:0]  HTIM_OFF   = 8'h04;
  localparam logic [7:0]  VTIM_OFF   = 8'h08;
  localparam logic [7:0]  SIZE_OFF   = 8'h0C;
  localparam logic [7:0]  CLKDIV_OFF = 8'h10;
  localparam logic [7:0]  SEG_OFF    = 8'h14;
  localparam logic [7:0]  STAT_OFF   = 8'h18;

  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] HTIM_RST   = 32'h0000_0000;
  localparam logic [31:0] VTIM_RST   = 32'h0001_0000;
  localparam logic [31:0] SIZE_RST   = 32'h00F0_0140;
  localparam logic [31:0] CLKDIV_RST = 32'h0000_0003;
  localparam logic [31:0] SEG_RST    = 32'h0000_0000;

  // control register fields
  localparam int CTRL_EN     = 0;
  localparam int CTRL_MODE   = 1;
  localparam int CTRL_BW     = 3;
  localparam int CTRL_SCKPOL = 5;
  localparam int CTRL_DATPOL = 6;
  localparam int CTRL_FSPOL  = 7;
  localparam int CTRL_LSPOL  = 8;
  localparam int CTRL_OEPOL  = 9;
  localparam int CTRL_STOPFS = 10;
  localparam int CTRL_STOPOE = 11;
  localparam int CTRL_BITS   = 12;

  // field positions shared by the timing and segment registers
  localparam int F0 = 0;
  localparam int F1 = 8;
  localparam int F2 = 16;
  localparam int F3 = 24;

  localparam logic [1:0] MODE_ACTIVE  = 2'h0;
  localparam logic [1:0] MODE_SEGMENT = 2'h1;
  localparam logic [1:0] MODE_PASCOL  = 2'h2;
  localparam logic [1:0] MODE_MONO    = 2'h3;

  // porch additions per mode, in counting units
  localparam logic [11:0] AM_BACK_ADD  = 12'h003;
  localparam logic [11:0] SEG_BACK_ADD = 12'h004;
  localparam logic [11:0] PAS_BACK_ADD = 12'h002;

  typedef enum logic [1:0] {
    H_SYNC   = 2'b00,
    H_BACK   = 2'b01,
    H_ACTIVE = 2'b11,
    H_FRONT  = 2'b10
  } lpt_hstate_t;

  typedef enum logic [1:0] {
    V_ACTIVE = 2'b00,
    V_FRONT  = 2'b01,
    V_SYNC   = 2'b11,
    V_BACK   = 2'b10
  } lpt_vstate_t;
endpackage
`default_nettype wire

// ==== hdl/lpt_tick_div.sv ====
// programmable divider giving a one-cycle tick every div+1 steps
`default_nettype none
module lpt_tick_div #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         run,
  input  wire logic         step,
  input  wire logic [W-1:0] div,
  output logic              tick
);
  logic [W-1:0] cnt_q;

  assign tick = run && step && (cnt_q >= div);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (!run) begin
        cnt_q <= '0;
      end else if (tick) begin
        cnt_q <= '0;
      end else if (step) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/lpt_timing.sv ====
// panel timing generator: apb registers, clocks, line and frame timing
`default_nettype none
// Behaviour
// RULE_01 - pixel clock is the source clock divided by divisor plus one
// RULE_02 - shift clock equals pixel clock except in wide monochrome
// RULE_03 - wide monochrome shift clock is pixel clock over bus width
// RULE_04 - shift clock and pixel data polarity are software selected
// RULE_05 - software keeps shift clock under a third of bus clock
// RULE_06 - frame sync starts front wait lines plus porches less one
// RULE_07 - line period is pixels plus sync width and both porches
// RULE_08 - frame sync lasts sync-width lines; enable resumes back wait +1
// RULE_09 - line sync lasts width+1; enable starts back wait+3 later
// RULE_10 - line sync starts front wait+1 after output enable ends
// RULE_11 - frame sync, line sync and enable polarities are selectable
// RULE_12 - shift clock may stop during frame sync or enable off
// RULE_13 - segmented start pulse is one shift clock, ends at first data
// RULE_14 - segmented line sync starts front wait+1 after last data
// RULE_15 - segmented data starts back wait+4 after line sync ends
// RULE_16 - gate clock rises delay+1 after data, stays high width+1
// RULE_17 - power save rises delay after gate falls, falls on gate rise
// RULE_18 - reverse output toggles once a line, delay+1 after last data
// RULE_19 - passive: back wait+2, sync width+1, front wait+1 pixel clocks
// RULE_20 - passive frame sync, line sync, shift clock polarity selectable
// RULE_21 - passive colour and one-bit mono frame-to-shift delay is one
// RULE_22 - mono 2, 4, 8 bit bus delay 1, 2, 4 pixel clocks
// RULE_23 - counters held at start in reset, frame begins after release
module lpt_timing #(
  parameter int DW = 8
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [DW-1:0] pixel_in,
  output logic               pixel_req,
  output logic      [DW-1:0] pixel_data_out,
  output logic               shift_clock,
  output logic               line_sync,
  output logic               frame_sync,
  output logic               output_enable,
  output logic               line_start_pulse,
  output logic               gate_clock,
  output logic               power_save_out,
  output logic               polarity_reverse
);
  logic [lpt_pkg::CTRL_BITS-1:0] ctrl_q;
  logic [31:0]          htim_q;
  logic [31:0]          vtim_q;
  logic [31:0]          size_q;
  logic [5:0]           pcd_q;
  logic [31:0]          seg_q;
  logic                 setup;
  logic                 hit;
  logic [31:0]          rd_d;
  logic                 en;
  logic [1:0]           mode;
  logic                 passive;
  logic                 segm;
  logic [3:0]           bw_div;
  logic                 pix_tick;
  logic                 sh_tick;
  lpt_pkg::lpt_hstate_t hstate_q;
  lpt_pkg::lpt_vstate_t vstate_q;
  logic [11:0]          hcnt_q;
  logic [9:0]           vcnt_q;
  logic [11:0]          hlen;
  logic [11:0]          back_add;
  logic                 step;
  logic                 h_last;
  logic                 line_end;
  logic                 back_end;
  logic                 fs_q;
  logic                 oe_act;
  logic [2:0]           dly_q;
  logic [2:0]           dly_ld;
  logic                 sck_run;
  logic [9:0]           seg_cnt_q;
  logic [9:0]           g_on;
  logic [9:0]           g_off;
  logic [9:0]           ps_on;
  logic [9:0]           rev_at;
  logic                 gate_q;
  logic                 ps_q;
  logic                 rev_q;

  assign en      = ctrl_q[lpt_pkg::CTRL_EN];
  assign mode    = ctrl_q[lpt_pkg::CTRL_MODE +: 2];
  assign passive = mode[1];
  assign segm    = (mode == lpt_pkg::MODE_SEGMENT);

  // apb slave, zero wait states
  assign pready  = 1'b1;
  assign setup   = psel && !penable;
  assign pslverr = psel && penable && !hit;

  always_comb begin
    hit  = 1'b1;
    rd_d = 32'h0000_0000;
    if (paddr == lpt_pkg::CTRL_OFF) begin
      rd_d = {20'h00000, ctrl_q};
    end else if (paddr == lpt_pkg::HTIM_OFF) begin
      rd_d = htim_q;
    end else if (paddr == lpt_pkg::VTIM_OFF) begin
      rd_d = vtim_q;
    end else if (paddr == lpt_pkg::SIZE_OFF) begin
      rd_d = size_q;
    end else if (paddr == lpt_pkg::CLKDIV_OFF) begin
      rd_d = {26'h0000000, pcd_q};
    end else if (paddr == lpt_pkg::SEG_OFF) begin
      rd_d = seg_q;
    end else if (paddr == lpt_pkg::STAT_OFF) begin
      rd_d = {12'h000, vstate_q, hstate_q, fs_q, oe_act, 4'h0, vcnt_q};
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && setup && !pwrite) begin
      prdata <= rd_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= lpt_pkg::CTRL_RST[lpt_pkg::CTRL_BITS-1:0];
      htim_q <= lpt_pkg::HTIM_RST;
      vtim_q <= lpt_pkg::VTIM_RST;
      size_q <= lpt_pkg::SIZE_RST;
      pcd_q  <= lpt_pkg::CLKDIV_RST[5:0];
      seg_q  <= lpt_pkg::SEG_RST;
    end else if (ce && psel && penable && pwrite) begin
      if (paddr == lpt_pkg::CTRL_OFF) begin
        ctrl_q <= pwdata[lpt_pkg::CTRL_BITS-1:0];
      end else if (paddr == lpt_pkg::HTIM_OFF) begin
        htim_q <= pwdata;
      end else if (paddr == lpt_pkg::VTIM_OFF) begin
        vtim_q <= pwdata;
      end else if (paddr == lpt_pkg::SIZE_OFF) begin
        size_q <= pwdata;
      end else if (paddr == lpt_pkg::CLKDIV_OFF) begin
        pcd_q <= pwdata[5:0];
      end else if (paddr == lpt_pkg::SEG_OFF) begin
        seg_q <= pwdata;
      end
    end
  end

  // clock generation
  lpt_tick_div #(.W(6)) u_pix (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (ce),
    .run   (en),
    .step  (1'b1),
    .div   (pcd_q),
    .tick  (pix_tick)
  ); // RULE_01

  always_comb begin
    bw_div = 4'h0; // RULE_02
    dly_ld = 3'h1; // RULE_21
    if (mode == lpt_pkg::MODE_MONO) begin
      case (ctrl_q[lpt_pkg::CTRL_BW +: 2])
        2'h1: begin
          bw_div = 4'h1; // RULE_03
        end
        2'h2: begin
          bw_div = 4'h3;
          dly_ld = 3'h2; // RULE_22
        end
        2'h3: begin
          bw_div = 4'h7;
          dly_ld = 3'h4; // RULE_22
        end
        default: begin
          bw_div = 4'h0;
        end
      endcase
    end
  end

  lpt_tick_div #(.W(4)) u_shift (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (ce),
    .run   (en),
    .step  (pix_tick),
    .div   (bw_div),
    .tick  (sh_tick)
  ); // RULE_03

  // horizontal phase lengths
  always_comb begin
    if (passive) begin
      back_add = lpt_pkg::PAS_BACK_ADD; // RULE_19
    end else if (segm) begin
      back_add = lpt_pkg::SEG_BACK_ADD; // RULE_15
    end else begin
      back_add = lpt_pkg::AM_BACK_ADD; // RULE_09
    end
    case (hstate_q)
      lpt_pkg::H_SYNC: begin
        hlen = {4'h0, htim_q[lpt_pkg::F0 +: 8]} + 12'h001; // RULE_09
      end
      lpt_pkg::H_BACK: begin
        hlen = {4'h0, htim_q[lpt_pkg::F2 +: 8]} + back_add;
      end
      lpt_pkg::H_ACTIVE: begin
        hlen = size_q[11:0]; // RULE_07
      end
      default: begin
        hlen = {4'h0, htim_q[lpt_pkg::F1 +: 8]} + 12'h001; // RULE_10 RULE_14
      end
    endcase
  end

  // data counts in shift clocks; porches in pixel clocks (equal unless wide mono)
  assign step     = (hstate_q == lpt_pkg::H_ACTIVE) ? sh_tick : pix_tick;
  assign h_last   = step && (hcnt_q == hlen - 12'h001);
  assign line_end = h_last && (hstate_q == lpt_pkg::H_FRONT);
  assign back_end = step && (hstate_q == lpt_pkg::H_BACK) &&
                    (hcnt_q == hlen - {10'h0, !passive, passive});
  assign oe_act   = (hstate_q == lpt_pkg::H_ACTIVE) &&
                    (vstate_q == lpt_pkg::V_ACTIVE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hstate_q <= lpt_pkg::H_SYNC; // RULE_23
      hcnt_q   <= 12'h000;
    end else if (ce) begin
      if (!en) begin
        hstate_q <= lpt_pkg::H_SYNC;
        hcnt_q   <= 12'h000;
      end else if (h_last) begin
        hcnt_q <= 12'h000;
        case (hstate_q)
          lpt_pkg::H_SYNC: begin
            hstate_q <= lpt_pkg::H_BACK;
          end
          lpt_pkg::H_BACK: begin
            hstate_q <= lpt_pkg::H_ACTIVE;
          end
          lpt_pkg::H_ACTIVE: begin
            hstate_q <= lpt_pkg::H_FRONT;
          end
          default: begin
            hstate_q <= lpt_pkg::H_SYNC;
          end
        endcase
      end else if (step) begin
        hcnt_q <= hcnt_q + 12'h001;
      end
    end
  end

  // vertical sequence, advanced at each line end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vstate_q <= lpt_pkg::V_ACTIVE; // RULE_23
      vcnt_q   <= 10'h000;
    end else if (ce) begin
      if (!en) begin
        vstate_q <= lpt_pkg::V_ACTIVE;
        vcnt_q   <= 10'h000;
      end else if (line_end) begin
        vcnt_q <= vcnt_q + 10'h001;
        case (vstate_q)
          lpt_pkg::V_ACTIVE: begin
            if (vcnt_q + 10'h001 >= size_q[25:16]) begin
              vcnt_q <= 10'h000;
              if (vtim_q[lpt_pkg::F1 +: 8] != 8'h00) begin
                vstate_q <= lpt_pkg::V_FRONT; // RULE_06
              end else begin
                vstate_q <= lpt_pkg::V_SYNC;
              end
            end
          end
          lpt_pkg::V_FRONT: begin
            if (vcnt_q + 10'h001 >= {2'h0, vtim_q[lpt_pkg::F1 +: 8]}) begin
              vcnt_q   <= 10'h000;
              vstate_q <= lpt_pkg::V_SYNC; // RULE_06
            end
          end
          lpt_pkg::V_SYNC: begin
            if (vcnt_q + 10'h001 >= {2'h0, vtim_q[lpt_pkg::F0 +: 8]}) begin
              vcnt_q <= 10'h000;
              if (vtim_q[lpt_pkg::F2 +: 8] != 8'h00) begin
                vstate_q <= lpt_pkg::V_BACK; // RULE_08
              end else begin
                vstate_q <= lpt_pkg::V_ACTIVE;
              end
            end
          end
          default: begin
            if (vcnt_q + 10'h001 >= {2'h0, vtim_q[lpt_pkg::F2 +: 8]}) begin
              vcnt_q   <= 10'h000;
              vstate_q <= lpt_pkg::V_ACTIVE; // RULE_08
            end
          end
        endcase
      end
    end
  end

  // frame sync changes one shift clock before data would start, or as data starts in the passive modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_q <= 1'b0;
    end else if (ce) begin
      if (!en) begin
        fs_q <= 1'b0;
      end else if (back_end) begin
        fs_q <= (vstate_q == lpt_pkg::V_SYNC); // RULE_06 RULE_08 RULE_19
      end
    end
  end

  // passive frame-sync to shift-clock delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_q <= 3'h0;
    end else if (ce) begin
      if (passive && back_end && (vstate_q == lpt_pkg::V_SYNC) && !fs_q) begin
        dly_q <= dly_ld; // RULE_21 RULE_22
      end else if (pix_tick && dly_q != 3'h0) begin
        dly_q <= dly_q - 3'h1;
      end
    end
  end

  assign sck_run = en && (dly_q == 3'h0) &&
                   !(ctrl_q[lpt_pkg::CTRL_STOPFS] && fs_q) &&
                   !(ctrl_q[lpt_pkg::CTRL_STOPOE] && !oe_act); // RULE_12

  // segmented panel strobes, timed from the last data of a line
  assign g_on   = {2'h0, seg_q[lpt_pkg::F0 +: 8]} + 10'h001;
  assign g_off  = g_on + {2'h0, seg_q[lpt_pkg::F1 +: 8]} + 10'h001;
  assign ps_on  = g_off + {2'h0, seg_q[lpt_pkg::F2 +: 8]};
  assign rev_at = {2'h0, seg_q[lpt_pkg::F3 +: 8]} + 10'h001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_cnt_q <= 10'h3FF;
    end else if (ce) begin
      if (!en || !segm) begin
        seg_cnt_q <= 10'h3FF;
      end else if (h_last && hstate_q == lpt_pkg::H_ACTIVE) begin
        seg_cnt_q <= 10'h000;
      end else if (sh_tick && seg_cnt_q != 10'h3FF) begin
        seg_cnt_q <= seg_cnt_q + 10'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q <= 1'b0;
      ps_q   <= 1'b0;
      rev_q  <= 1'b0;
    end else if (ce) begin
      if (!en || !segm) begin
        gate_q <= 1'b0;
        ps_q   <= 1'b0;
        rev_q  <= 1'b0;
      end else begin
        gate_q <= (seg_cnt_q >= g_on) && (seg_cnt_q < g_off); // RULE_16
        if (seg_cnt_q == g_on) begin
          ps_q <= 1'b0; // RULE_17
        end else if (seg_cnt_q == ps_on) begin
          ps_q <= 1'b1; // RULE_17
        end
        if (sh_tick && seg_cnt_q == rev_at - 10'h001) begin
          rev_q <= !rev_q; // RULE_18
        end
      end
    end
  end

  // pin outputs, registered except pixel_req; polarity programmable on data, shift clock, syncs and enable
  assign pixel_req = oe_act && sh_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pixel_data_out   <= '0;
      shift_clock      <= 1'b0;
      line_sync        <= 1'b0;
      frame_sync       <= 1'b0;
      output_enable    <= 1'b0;
      line_start_pulse <= 1'b0;
      gate_clock       <= 1'b0;
      power_save_out   <= 1'b0;
      polarity_reverse <= 1'b0;
    end else if (ce) begin
      if (pixel_req) begin
        pixel_data_out <= pixel_in ^ {DW{ctrl_q[lpt_pkg::CTRL_DATPOL]}}; // RULE_04
      end
      shift_clock <= (sh_tick && sck_run) ^
                     ctrl_q[lpt_pkg::CTRL_SCKPOL]; // RULE_04 RULE_20
      line_sync <= (en && hstate_q == lpt_pkg::H_SYNC) ^
                   ctrl_q[lpt_pkg::CTRL_LSPOL]; // RULE_11 RULE_20
      frame_sync <= fs_q ^ ctrl_q[lpt_pkg::CTRL_FSPOL]; // RULE_11 RULE_20
      output_enable <= (en && oe_act) ^
                       ctrl_q[lpt_pkg::CTRL_OEPOL]; // RULE_11
      line_start_pulse <= en && segm && (hstate_q == lpt_pkg::H_BACK) &&
                          (hcnt_q == hlen - 12'h001); // RULE_13
      gate_clock       <= gate_q;
      power_save_out   <= ps_q;
      polarity_reverse <= rev_q;
    end
  end
endmodule
`default_nettype wire
